// ### pkg/sfsp_pkg.sv
// constants, types and timing for the serial flash status and protection block
package sfsp_pkg;

  // command codes
  localparam logic [7:0] CMD_LATCH_SET = 8'h06;
  localparam logic [7:0] CMD_LATCH_CLEAR = 8'h04;
  localparam logic [7:0] CMD_IDENT_READ = 8'h9F;
  localparam logic [7:0] CMD_STATUS_READ = 8'h05;
  localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
  localparam logic [7:0] CMD_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'hD8;
  localparam logic [7:0] CMD_BULK_ERASE = 8'hC7;
  localparam logic [7:0] CMD_NONE = 8'h00;

  // status byte field positions
  localparam int ST_WIP_BIT = 0;
  localparam int ST_WEL_BIT = 1;
  localparam int ST_BP_LSB = 2;
  localparam int ST_BP_MSB = 4;
  localparam int ST_STATUS_WRITE_DISABLE_BIT = 7;

  // frame counting
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [3:0] BYTES_MAX = 4'hF;
  localparam logic [3:0] BYTES_ONE = 4'h1;
  localparam logic [3:0] BYTES_STATUS_WRITE = 4'h2;
  localparam logic [3:0] BYTES_SECTOR_ERASE = 4'h4;
  localparam logic [3:0] BYTES_PAGE_MIN = 4'h5;
  localparam logic [1:0] ID_LAST = 2'h2;

  // reset values of the kept protection bits (initial delivery state)
  localparam logic [2:0] BP_RESET = 3'h0;
  localparam logic STATUS_WRITE_DISABLE_RESET = 1'b0;

  // timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int STATUS_WRITE_TIME_NS = 5000000;
  localparam int STATUS_WRITE_CYCLES =
    (STATUS_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // frame phase
  typedef enum logic [2:0] {
    PH_CMD,
    PH_IDENT,
    PH_STATUS,
    PH_WRITE_DATA,
    PH_SINK,
    PH_IGNORE
  } sfsp_phase_t;

endpackage

// ### rtl/sfsp_sync.sv
// two-flop synchroniser for a group of pin inputs
module sfsp_sync #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // pins and synchronised copy
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1; // metastable stage, read only by stage2
    logic [WIDTH-1:0] stage2; // safe copy
  } sfsp_sync_state_t;

  sfsp_sync_state_t st_reg;
  sfsp_sync_state_t st_next;

  // shift the pins through both stages
  always_comb begin
    st_next = st_reg;
    st_next.stage1 = async_in;
    st_next.stage2 = st_reg.stage1;
  end

  // register, reset to the idle pin levels
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_reg <= {RESET_VAL, RESET_VAL};
    end else begin
      st_reg <= st_next;
    end
  end

  assign sync_out = st_reg.stage2;

endmodule // sfsp_sync

// ### rtl/sfsp_cycle_timer.sv
// self-timed cycle counter for the status write cycle
module sfsp_cycle_timer #(
  parameter int CYCLES = 4
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // control
  input wire logic start_in,
  output logic busy_out,
  output logic done_out
);

  localparam int CNT_W = $clog2(CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  typedef struct packed {
    logic [CNT_W-1:0] cnt; // cycles elapsed
    logic busy; // cycle running
    logic done; // one-cycle pulse at the end
  } sfsp_timer_state_t;

  sfsp_timer_state_t st_reg;
  sfsp_timer_state_t st_next;

  // count while busy; a start while busy is ignored
  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    if (st_reg.busy) begin
      if (st_reg.cnt == CNT_LAST) begin
        st_next.busy = 1'b0;
        st_next.done = 1'b1;
      end else begin
        st_next.cnt = st_reg.cnt + CNT_ONE;
      end
    end else if (start_in) begin
      st_next.busy = 1'b1;
      st_next.cnt = '0;
    end
  end

  // state register
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign busy_out = st_reg.busy;
  assign done_out = st_reg.done;

endmodule // sfsp_cycle_timer

// ### rtl/sfsp_core.sv
// serial command decoder, status register and write protection logic
module sfsp_core
  import sfsp_pkg::*;
#(
  parameter int STATUS_WRITE_CYCLES_P = STATUS_WRITE_CYCLES,
  parameter logic [7:0] MAKER_CODE = 8'hA5, // arbitrary value
  parameter logic [7:0] TYPE_CODE = 8'h5A, // arbitrary value
  parameter logic [7:0] SIZE_CODE = 8'h3C // arbitrary value
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // serial pins
  input wire logic chip_select_n_in,
  input wire logic serial_clock_in,
  input wire logic serial_in_in,
  input wire logic write_protect_n_in,
  output logic serial_out_out,
  output logic serial_out_oe_out,
  // array engine, same clock
  input wire logic array_busy_in,
  input wire logic array_done_in,
  output logic page_program_req_out,
  output logic sector_erase_req_out,
  output logic bulk_erase_req_out,
  // status view
  output logic write_in_progress_out,
  output logic write_enable_latch_out,
  output logic [2:0] block_protect_out,
  output logic status_write_disable_out,
  output logic hardware_protected_mode_out
);

  typedef struct packed {
    sfsp_phase_t phase; // where the frame stands
    logic sclk_d; // previous synced clock, for edges
    logic cs_n_d; // previous synced select, for edges
    logic [2:0] bit_cnt; // bit within current byte
    logic [3:0] byte_cnt; // whole bytes in frame, saturating
    logic [7:0] shift_in; // incoming bits
    logic [7:0] cmd; // decoded command of this frame
    logic [7:0] wr_data; // status write data byte
    logic [7:0] out_shift; // outgoing bits
    logic [2:0] out_cnt; // bit within outgoing byte
    logic [1:0] id_idx; // ident byte now in out_shift
    logic write_enable_latch; // write enable latch
    logic [2:0] bp; // block protect bits
    logic status_write_disable; // status write disable
    logic [2:0] pend_bp; // values waiting for the cycle end
    logic pend_status_write_disable;
    logic sw_start; // start pulse to the timer
    logic write_in_progress; // write in progress
    logic hardware_protected_mode; // hardware protected mode
    logic q; // serial output level
    logic q_oe; // serial output driven
    logic pp_req; // page program accepted
    logic se_req; // sector erase accepted
    logic be_req; // bulk erase accepted
  } sfsp_core_state_t;

  sfsp_core_state_t st_reg;
  sfsp_core_state_t st_next;

  logic [3:0] pins_sync; // {cs_n, sclk, si, wp_n}
  logic cs_n_s;
  logic sclk_s;
  logic si_s;
  logic wp_n_s;
  logic tmr_busy;
  logic tmr_done;

  // pins are foreign to clk_in; select idles high, wp idles high
  sfsp_sync #(
    .WIDTH(4),
    .RESET_VAL(4'h9)
  ) u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .async_in({chip_select_n_in, serial_clock_in, serial_in_in, write_protect_n_in}),
    .sync_out(pins_sync)
  );

  assign cs_n_s = pins_sync[3];
  assign sclk_s = pins_sync[2];
  assign si_s = pins_sync[1];
  assign wp_n_s = pins_sync[0];

  // self-timed status write cycle
  sfsp_cycle_timer #(
    .CYCLES(STATUS_WRITE_CYCLES_P)
  ) u_timer (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .start_in(st_reg.sw_start),
    .busy_out(tmr_busy),
    .done_out(tmr_done)
  );

  // status byte as it is shifted out
  function automatic logic [7:0] status_byte(input sfsp_core_state_t s);
    logic [7:0] b;
    b = 8'h00; // bits 6 and 5 always read zero
    b[ST_WIP_BIT] = s.write_in_progress;
    b[ST_WEL_BIT] = s.write_enable_latch;
    b[ST_BP_MSB:ST_BP_LSB] = s.bp;
    b[ST_STATUS_WRITE_DISABLE_BIT] = s.status_write_disable;
    return b;
  endfunction

  // whole behaviour of the block in one pass
  always_comb begin
    logic rise;
    logic fall;
    logic cs_rise;
    logic busy_any;
    logic aligned;
    logic [7:0] in_byte;
    rise = 1'b0;
    fall = 1'b0;
    cs_rise = 1'b0;
    busy_any = 1'b0;
    aligned = 1'b0;
    in_byte = 8'h00;
    st_next = st_reg;
    st_next.sclk_d = sclk_s;
    st_next.cs_n_d = cs_n_s;
    st_next.sw_start = 1'b0;
    st_next.pp_req = 1'b0;
    st_next.se_req = 1'b0;
    st_next.be_req = 1'b0;

    rise = sclk_s & ~st_reg.sclk_d & ~cs_n_s;
    fall = ~sclk_s & st_reg.sclk_d & ~cs_n_s;
    cs_rise = cs_n_s & ~st_reg.cs_n_d;
    in_byte = {st_reg.shift_in[6:0], si_s}; // msb arrives first
    // anything accepted but not yet visible on the timer also counts
    busy_any = st_reg.write_in_progress | st_reg.sw_start | st_reg.pp_req |
               st_reg.se_req | st_reg.be_req;

    // the timer, its start pulse and a busy array engine raise wip
    st_next.write_in_progress = tmr_busy | st_reg.sw_start | array_busy_in;

    // cycle completions clear the latch; a latch-set below still wins
    if (tmr_done) begin
      st_next.bp = st_reg.pend_bp; // only path that changes bp
      st_next.status_write_disable = st_reg.pend_status_write_disable;
      st_next.write_enable_latch = 1'b0;
    end
    if (array_done_in) begin
      st_next.write_enable_latch = 1'b0;
    end
    // built from the new disable bit so that mode and bit never disagree
    st_next.hardware_protected_mode = st_next.status_write_disable & ~wp_n_s;

    // serial input side
    if (rise) begin
      st_next.shift_in = in_byte;
      st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
      if (st_reg.bit_cnt == BIT_LAST) begin
        if (st_reg.byte_cnt != BYTES_MAX) begin
          st_next.byte_cnt = st_reg.byte_cnt + 4'h1;
        end
        unique case (st_reg.phase)
          PH_CMD: begin
            st_next.cmd = in_byte;
            st_next.out_cnt = BIT_FIRST;
            if (in_byte == CMD_IDENT_READ) begin
              if (busy_any) begin
                st_next.phase = PH_IGNORE; // not decoded while busy
              end else begin
                st_next.phase = PH_IDENT;
                st_next.out_shift = MAKER_CODE;
                st_next.id_idx = 2'h0;
              end
            end else if (in_byte == CMD_STATUS_READ) begin
              st_next.phase = PH_STATUS; // even while busy
              st_next.out_shift = status_byte(st_reg);
            end else if (in_byte == CMD_STATUS_WRITE) begin
              st_next.phase = PH_WRITE_DATA;
            end else begin
              st_next.phase = PH_SINK;
            end
          end
          PH_WRITE_DATA: begin
            if (st_reg.byte_cnt == BYTES_ONE) begin
              st_next.wr_data = in_byte;
            end
          end
          PH_IDENT, PH_STATUS, PH_SINK, PH_IGNORE: begin
            // trailing bytes are only counted
          end
        endcase
      end
    end

    // serial output side, updated on falling edges
    if (fall && (st_reg.phase == PH_IDENT || st_reg.phase == PH_STATUS)) begin
      st_next.q = st_reg.out_shift[7];
      st_next.out_cnt = st_reg.out_cnt + 3'h1;
      if (st_reg.out_cnt == BIT_LAST) begin
        if (st_reg.phase == PH_STATUS) begin
          st_next.out_shift = status_byte(st_reg); // repeats, fresh wip
        end else if (st_reg.id_idx == 2'h0) begin
          st_next.out_shift = TYPE_CODE;
          st_next.id_idx = 2'h1;
        end else if (st_reg.id_idx == 2'h1) begin
          st_next.out_shift = SIZE_CODE;
          st_next.id_idx = ID_LAST;
        end else begin
          st_next.out_shift = 8'h00; // past the third byte only zeros
        end
      end else begin
        st_next.out_shift = {st_reg.out_shift[6:0], 1'b0};
      end
    end

    // end of frame: write-type commands act only here
    aligned = (st_reg.bit_cnt == BIT_FIRST);
    if (cs_rise && aligned && st_reg.phase != PH_IGNORE) begin
      if (st_reg.cmd == CMD_LATCH_SET && st_reg.byte_cnt == BYTES_ONE) begin
        st_next.write_enable_latch = 1'b1;
      end
      if (st_reg.cmd == CMD_LATCH_CLEAR && st_reg.byte_cnt == BYTES_ONE) begin
        st_next.write_enable_latch = 1'b0;
      end
      // exactly one data byte, latch set, not hardware protected
      if (st_reg.cmd == CMD_STATUS_WRITE && st_reg.byte_cnt == BYTES_STATUS_WRITE &&
          st_reg.write_enable_latch && !st_reg.hardware_protected_mode && !busy_any) begin
        st_next.sw_start = 1'b1;
        st_next.pend_bp = st_reg.wr_data[ST_BP_MSB:ST_BP_LSB];
        st_next.pend_status_write_disable = st_reg.wr_data[ST_STATUS_WRITE_DISABLE_BIT]; // b6,b5,b1,b0 dropped
      end
      // area checks for program and sector erase stay with the array engine
      if (st_reg.cmd == CMD_PAGE_PROGRAM && st_reg.byte_cnt >= BYTES_PAGE_MIN &&
          st_reg.write_enable_latch && !busy_any) begin
        st_next.pp_req = 1'b1;
      end
      if (st_reg.cmd == CMD_SECTOR_ERASE && st_reg.byte_cnt == BYTES_SECTOR_ERASE &&
          st_reg.write_enable_latch && !busy_any) begin
        st_next.se_req = 1'b1;
      end
      if (st_reg.cmd == CMD_BULK_ERASE && st_reg.byte_cnt == BYTES_ONE &&
          st_reg.write_enable_latch && st_reg.bp == BP_RESET && !busy_any) begin
        st_next.be_req = 1'b1;
      end
    end

    // deselected: standby, frame counters ready for the next select
    if (cs_n_s) begin
      st_next.phase = PH_CMD;
      st_next.bit_cnt = BIT_FIRST;
      st_next.byte_cnt = 4'h0;
      st_next.cmd = CMD_NONE;
      st_next.out_cnt = BIT_FIRST;
      st_next.q = 1'b0;
    end

    // drive the output only during a read data phase
    st_next.q_oe = ~cs_n_s &
                   (st_next.phase == PH_IDENT || st_next.phase == PH_STATUS);
  end

  // state register; protection bits come up in delivery state
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_reg <= '0; // latch clear at power-up
      st_reg.phase <= PH_CMD;
      st_reg.sclk_d <= 1'b0;
      st_reg.cs_n_d <= 1'b1;
      st_reg.bp <= BP_RESET;
      st_reg.status_write_disable <= STATUS_WRITE_DISABLE_RESET;
      st_reg.pend_bp <= BP_RESET;
      st_reg.pend_status_write_disable <= STATUS_WRITE_DISABLE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register
  assign serial_out_out = st_reg.q;
  assign serial_out_oe_out = st_reg.q_oe;
  assign page_program_req_out = st_reg.pp_req;
  assign sector_erase_req_out = st_reg.se_req;
  assign bulk_erase_req_out = st_reg.be_req;
  assign write_in_progress_out = st_reg.write_in_progress;
  assign write_enable_latch_out = st_reg.write_enable_latch;
  assign block_protect_out = st_reg.bp;
  assign status_write_disable_out = st_reg.status_write_disable;
  assign hardware_protected_mode_out = st_reg.hardware_protected_mode;

endmodule // sfsp_core

// ### verification/sfsp_core_sva.sv
// concurrent checks on the status and protection block ports
module sfsp_core_sva #(
  parameter int STATUS_WRITE_CYCLES_P = 4
) (
  // clock, reset and serial pins
  input logic clk_in, rst_in, chip_select_n_in, serial_clock_in,
  input logic serial_in_in, write_protect_n_in, serial_out_out, serial_out_oe_out,
  // array engine
  input logic array_busy_in, array_done_in,
  input logic page_program_req_out, sector_erase_req_out, bulk_erase_req_out,
  // status view
  input logic write_in_progress_out, write_enable_latch_out,
  input logic [2:0] block_protect_out,
  input logic status_write_disable_out, hardware_protected_mode_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // length of a busy run that the array engine does not explain
  logic [31:0] wip_cnt_reg;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wip_cnt_reg <= 32'h0;
    end else if (!write_in_progress_out || array_busy_in) begin
      wip_cnt_reg <= 32'h0;
    end else begin
      wip_cnt_reg <= wip_cnt_reg + 32'h1;
    end
  end
  // any accepted array request
  sequence s_req;
    page_program_req_out || sector_erase_req_out || bulk_erase_req_out;
  endsequence
  // end of a timed status write, engine idle meanwhile
  sequence s_sw_end;
    $fell(write_in_progress_out) && !$past(array_busy_in) && !$past(array_busy_in, 2);
  endsequence
  // select seen high at the two previous edges: a frame has closed
  sequence s_closed;
    $past(chip_select_n_in) && $past(chip_select_n_in, 2);
  endsequence
  AST_WEL_AT_FRAME_END: assert property ($rose(write_enable_latch_out) |-> s_closed)
    else $error("latch rose outside a frame end");
  AST_REQ_NEEDS_WEL: assert property (s_req |-> $past(write_enable_latch_out))
    else $error("array request without latch");
  AST_BULK_BP_ZERO: assert property (bulk_erase_req_out |-> $past(block_protect_out) == 3'h0)
    else $error("bulk erase with protect bits set");
  AST_WIP_ARRAY: assert property (array_busy_in |=> write_in_progress_out)
    else $error("wip low while engine busy");
  AST_WIP_BOUND: assert property (wip_cnt_reg <= STATUS_WRITE_CYCLES_P + 4)
    else $error("timed cycle too long");
  AST_SW_END_WEL: assert property (s_sw_end |-> !write_enable_latch_out)
    else $error("latch kept after timed cycle");
  AST_BP_AT_CYCLE_END: assert property (!$stable({status_write_disable_out,
    block_protect_out}) |-> $past(write_in_progress_out))
    else $error("protect bits changed outside a timed cycle");
  AST_HPM_SET: assert property ((status_write_disable_out && !write_protect_n_in)[*4]
    |-> hardware_protected_mode_out)
    else $error("hardware mode not entered");
  AST_HPM_NEEDS_SWD: assert property (hardware_protected_mode_out |-> status_write_disable_out)
    else $error("hardware mode without disable bit");
  AST_OE_IDLE: assert property (chip_select_n_in[*5] |-> !serial_out_oe_out)
    else $error("output driven while deselected");
endmodule // sfsp_core_sva

bind sfsp_core sfsp_core_sva #(.STATUS_WRITE_CYCLES_P(STATUS_WRITE_CYCLES_P)) chk_u (
  .clk_in, .rst_in, .chip_select_n_in, .serial_clock_in, .serial_in_in,
  .write_protect_n_in, .serial_out_out, .serial_out_oe_out, .array_busy_in,
  .array_done_in, .page_program_req_out, .sector_erase_req_out, .bulk_erase_req_out,
  .write_in_progress_out, .write_enable_latch_out, .block_protect_out,
  .status_write_disable_out, .hardware_protected_mode_out);

// ### verification/sfsp_host_model.sv
// host side serial model: select, clock, data out and read data capture
module sfsp_host_model (
  // clock and read data line
  input wire logic clk_in,
  input wire logic miso_in,
  // link pins
  output logic cs_n_out,
  output logic sclk_out,
  output logic mosi_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle link; the serial clock stands low between frames
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    mosi_out = 1'b0;
  end
  // select; the first rise comes eight cycles later
  task begin_frame();
    cs_n_out <= 1'b0;
    repeat (4) @(posedge clk_in);
  endtask
  // one bit, mode 0: data set while low, read data taken at the rise
  task xfer_bit(input logic b, output logic r);
    mosi_out <= b;
    repeat (4) @(posedge clk_in);
    sclk_out <= 1'b1;
    r = miso_in;
    repeat (4) @(posedge clk_in);
    sclk_out <= 1'b0;
  endtask
  // whole byte, most significant bit first
  task xfer_byte(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      xfer_bit(b[i], r[i]);
    end
  endtask
  // deselect four cycles after the last bit; data line then shows the inverse
  task end_frame();
    repeat (4) @(posedge clk_in);
    cs_n_out <= 1'b1;
    mosi_out <= ~mosi_out;
    repeat (10) @(posedge clk_in);
  endtask
  // one-byte frame, used for the latch and bulk erase commands
  task cmd(input logic [7:0] c);
    logic [7:0] d;
    begin_frame();
    xfer_byte(c, d);
    end_frame();
  endtask
endmodule // sfsp_host_model

// ### verification/tb.sv
// self-checking bench for the status and protection block
module tb import sfsp_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  // timed cycle shortened, but longer than one status read
  localparam int SW_CYCLES = 400;
  localparam logic [7:0] ID_M = 8'h96; // arbitrary value
  localparam logic [7:0] ID_T = 8'h69; // arbitrary value
  localparam logic [7:0] ID_S = 8'h33; // arbitrary value
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic wp_n = 1'b1, busy = 1'b0, done = 1'b0, last_so = 1'b0;
  logic cs_n, sclk, mosi, miso, so, oe, pp, se, be, write_in_progress, write_enable_latch, swd, hardware_protected_mode;
  logic [2:0] bp;
  int error_cnt = 0, n_tests = 0, oe_cnt = 0;
  int req_cnt [3] = '{0, 0, 0};
  always #12.5 clk_in = ~clk_in;
  // released read line shows the inverse of its last driven level
  assign miso = oe ? so : ~last_so;
  // monitor: drive history and request pulses
  always @(posedge clk_in) begin
    if (oe === 1'b1) last_so <= so;
    oe_cnt <= oe_cnt + int'(oe === 1'b1);
    req_cnt[0] <= req_cnt[0] + int'(pp === 1'b1);
    req_cnt[1] <= req_cnt[1] + int'(se === 1'b1);
    req_cnt[2] <= req_cnt[2] + int'(be === 1'b1);
  end
  sfsp_core #(.STATUS_WRITE_CYCLES_P(SW_CYCLES), .MAKER_CODE(ID_M), .TYPE_CODE(ID_T),
    .SIZE_CODE(ID_S)) dut_u (
    .clk_in(clk_in), .rst_in(rst_in), .chip_select_n_in(cs_n), .serial_clock_in(sclk),
    .serial_in_in(mosi), .write_protect_n_in(wp_n), .serial_out_out(so),
    .serial_out_oe_out(oe), .array_busy_in(busy), .array_done_in(done),
    .page_program_req_out(pp), .sector_erase_req_out(se), .bulk_erase_req_out(be),
    .write_in_progress_out(write_in_progress), .write_enable_latch_out(write_enable_latch), .block_protect_out(bp),
    .status_write_disable_out(swd), .hardware_protected_mode_out(hardware_protected_mode));
  sfsp_host_model host_u (.clk_in(clk_in), .miso_in(miso), .cs_n_out(cs_n),
    .sclk_out(sclk), .mosi_out(mosi));
  task check_val(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task finish_test();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // status read of two bytes; the byte repeats while clocks go on
  task read_status(output logic [7:0] s);
    logic [7:0] d, s2;
    host_u.begin_frame();
    host_u.xfer_byte(CMD_STATUS_READ, d);
    host_u.xfer_byte(8'h00, s);
    host_u.xfer_byte(8'h00, s2);
    host_u.end_frame();
    check_val("status repeat", s, s2);
  endtask
  // command byte followed by n copies of one byte
  task frame_n(input logic [7:0] c, input logic [7:0] v, input int n);
    logic [7:0] d;
    host_u.begin_frame();
    host_u.xfer_byte(c, d);
    repeat (n) host_u.xfer_byte(v, d);
    host_u.end_frame();
  endtask
  // poll busy with a bound, no new command meanwhile
  task wait_idle();
    int k;
    for (k = 0; k < 1000 && write_in_progress !== 1'b0; k++) @(posedge clk_in);
    if (k == 1000) begin
      error_cnt++;
      $display("ERROR wip expected 0 seen %b", write_in_progress);
      finish_test();
    end
  endtask
  // array engine finishes: done pulse as busy drops
  task engine_end();
    busy <= 1'b0;
    done <= 1'b1;
    @(posedge clk_in);
    done <= 1'b0;
    repeat (4) @(posedge clk_in);
  endtask
  task t_reset();
    logic [7:0] s;
    read_status(s);
    check_val("status", 8'h00, s);
    $display("test reset done");
  endtask
  task t_latch();
    logic [7:0] s, d;
    logic b;
    host_u.cmd(CMD_LATCH_SET);
    check_val("wel", 8'h01, {7'h00, write_enable_latch});
    read_status(s);
    check_val("status", 8'h02, s);
    host_u.cmd(CMD_LATCH_CLEAR);
    check_val("wel", 8'h00, {7'h00, write_enable_latch});
    host_u.begin_frame();
    host_u.xfer_byte(CMD_LATCH_SET, d);
    host_u.xfer_bit(1'b0, b);
    host_u.end_frame();
    check_val("wel", 8'h00, {7'h00, write_enable_latch});
    $display("test latch done");
  endtask
  task t_ident();
    logic [7:0] d, m, t, c;
    logic b;
    host_u.begin_frame();
    host_u.xfer_byte(CMD_IDENT_READ, d);
    host_u.xfer_byte(8'h00, m);
    host_u.xfer_byte(8'h00, t);
    host_u.xfer_byte(8'h00, c);
    host_u.end_frame();
    check_val("maker", ID_M, m);
    check_val("type", ID_T, t);
    check_val("size", ID_S, c);
    host_u.begin_frame();
    host_u.xfer_byte(CMD_IDENT_READ, d);
    repeat (3) host_u.xfer_bit(1'b0, b);
    host_u.end_frame();
    check_val("oe", 8'h00, {7'h00, oe});
    read_status(d);
    check_val("status", 8'h00, d);
    $display("test ident done");
  endtask
  task t_swrite();
    logic [7:0] s;
    frame_n(CMD_STATUS_WRITE, 8'hFF, 1);
    read_status(s);
    check_val("status", 8'h00, s);
    host_u.cmd(CMD_LATCH_SET);
    frame_n(CMD_STATUS_WRITE, 8'hFF, 1);
    check_val("wip", 8'h01, {7'h00, write_in_progress});
    read_status(s);
    check_val("status", 8'h03, s);
    wait_idle();
    check_val("wel", 8'h00, {7'h00, write_enable_latch});
    read_status(s);
    check_val("status", 8'h9C, s);
    host_u.cmd(CMD_LATCH_SET);
    frame_n(CMD_STATUS_WRITE, 8'h00, 2);
    read_status(s);
    check_val("status", 8'h9E, s);
    $display("test status write done");
  endtask
  task t_protect();
    logic [7:0] s;
    wp_n <= 1'b0;
    repeat (6) @(posedge clk_in);
    check_val("hpm", 8'h01, {7'h00, hardware_protected_mode});
    frame_n(CMD_STATUS_WRITE, 8'h00, 1);
    read_status(s);
    check_val("status", 8'h9E, s);
    host_u.cmd(CMD_BULK_ERASE);
    check_val("bulk req", 8'h00, 8'(req_cnt[2]));
    wp_n <= 1'b1;
    repeat (6) @(posedge clk_in);
    check_val("hpm", 8'h00, {7'h00, hardware_protected_mode});
    frame_n(CMD_STATUS_WRITE, 8'h00, 1);
    wait_idle();
    read_status(s);
    check_val("status", 8'h00, s);
    host_u.cmd(CMD_LATCH_SET);
    host_u.cmd(CMD_BULK_ERASE);
    check_val("bulk req", 8'h01, 8'(req_cnt[2]));
    busy <= 1'b1;
    repeat (6) @(posedge clk_in);
    engine_end();
    check_val("wel", 8'h00, {7'h00, write_enable_latch});
    $display("test protect done");
  endtask
  task t_array();
    logic [7:0] s;
    int k;
    host_u.cmd(CMD_LATCH_SET);
    frame_n(CMD_SECTOR_ERASE, 8'h10, 3);
    check_val("sector req", 8'h01, 8'(req_cnt[1]));
    busy <= 1'b1;
    repeat (4) @(posedge clk_in);
    check_val("wip", 8'h01, {7'h00, write_in_progress});
    k = oe_cnt;
    frame_n(CMD_IDENT_READ, 8'h00, 1);
    check_val("ident oe", 8'h00, 8'(oe_cnt - k));
    read_status(s);
    check_val("status", 8'h03, s);
    engine_end();
    check_val("status", 8'h00, {6'h00, write_enable_latch, write_in_progress});
    frame_n(CMD_PAGE_PROGRAM, 8'h00, 4);
    check_val("page req", 8'h00, 8'(req_cnt[0]));
    host_u.cmd(CMD_LATCH_SET);
    frame_n(CMD_PAGE_PROGRAM, 8'h00, 4);
    check_val("page req", 8'h01, 8'(req_cnt[0]));
    $display("test array done");
  endtask
  initial begin
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    t_reset();
    t_latch();
    t_ident();
    t_swrite();
    t_protect();
    t_array();
    finish_test();
  end
endmodule // tb
